// [verilog/afe_ctrl_cfg.svh]
// Purpose: offsets, field positions and reset values of the front-end bank
// Assumes: APB byte addresses, one register per aligned 32-bit word
// Notes: definitions only
`ifndef AFE_CTRL_CFG_SVH
`define AFE_CTRL_CFG_SVH
// ======================================================
// register byte offsets
`define OFF_AMP_GAIN_REF 8'h00
`define OFF_INPUT_CONN 8'h04
`define OFF_CHAN_SEL 8'h08
`define OFF_LOWNOISE 8'h0c
`define OFF_DAC_HIGH 8'h10
`define OFF_DAC_LOW 8'h14
// ======================================================
// implemented-bit masks and reset values
`define MASK_INPUT_CONN 8'he0
`define MASK_LOWNOISE 8'h87
`define MASK_DAC_LOW 8'h0f
`define RST_BYTE 8'h00
// ======================================================
// field positions
`define POS_REF_PAIR 6
`define POS_CONV_GAIN 5
`define POS_AMP_EN 4
`define POS_AMP_BYP 3
`define POS_SHORT 7
`define POS_ROUTE 5
`define POS_NEG_SEL 4
`define POS_LN_EN 7
`define POS_LN_POS 2
`endif

// [verilog/afe_ctrl_pkg.sv]
// Purpose: types of the front-end control bank
// Assumes: constants live in afe_ctrl_cfg.svh
// Notes: mux codes are shared by both input selectors
package afe_ctrl_pkg;
   typedef enum logic [3:0] {
      MUX_PIN0 = 4'h0,
      MUX_PIN1 = 4'h1,
      MUX_PIN2 = 4'h2,
      MUX_PIN3 = 4'h3,
      MUX_VCM = 4'h8,
      MUX_DAC = 4'h9,
      MUX_TEMP = 4'ha,
      MUX_LNAMP = 4'hb,
      MUX_GND = 4'hf
   } mux_code_t;
   typedef enum logic [1:0] {
      REF_VCM = 2'h0,
      REF_VREG = 2'h1,
      REF_HALF = 2'h2,
      REF_QUARTER = 2'h3
   } ref_pair_t;
endpackage

// [verilog/mux_decode.sv]
// Purpose: one-hot decode of an input multiplexer code
// Assumes: same clock as the bank; output registered
// Notes: reserved codes give all zeros
`timescale 1ns/10ps
`default_nettype none
module mux_decode
   import afe_ctrl_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [3:0] code,
   output logic [8:0] onehot
);
   // bit order: pin0..pin3, vcm, dac, temp, lnamp, gnd
   logic [8:0] onehot_next;
   always_comb begin
      case (code)
         MUX_PIN0: onehot_next = 9'h001;
         MUX_PIN1: onehot_next = 9'h002;
         MUX_PIN2: onehot_next = 9'h004;
         MUX_PIN3: onehot_next = 9'h008;
         MUX_VCM: onehot_next = 9'h010;
         MUX_DAC: onehot_next = 9'h020;
         MUX_TEMP: onehot_next = 9'h040;
         MUX_LNAMP: onehot_next = 9'h080;
         MUX_GND: onehot_next = 9'h100;
         default: onehot_next = 9'h000;
      endcase
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         onehot <= 9'h000;
      end else begin
         onehot <= onehot_next;
      end
   end
endmodule // mux_decode
`default_nettype wire

// [verilog/afe_ctrl_regs.sv]
// Purpose: APB register bank steering the analog front end
// Assumes: single clock, synchronous active-high reset, zero-wait APB
// Notes: analog controls are registered decodes of the stored fields
//
// Functional notes
// - reference pair 00 vcm, 01 regulated, 10 half, 11 quarter
// - converter gain bit clear gives gain one, set gives gain two
// - amplifier enable gates every programmable amplifier function
// - bypass bit routes the input around the programmable amplifier
// - amplifier gain is two to the power of the three-bit field
// - input-short bit connects the two selected input ends
// - two-bit route field steers input ends to amplifier inputs
// - negative mux codes select pins, vcm, dac, sensor, lnamp, ground
// - positive mux uses same map, code 1010 is sensor positive
// - low-noise enable bit seven enables the low-noise amplifier
// - low-noise positive select chooses pin or common-mode voltage
// - low-noise switch bits close their switches when set
// - unimplemented bits ignore writes and read as zero
// - dac low register holds code bits three to zero
// - dac low write fills shadow; high write copies shadow to low
// - implemented bits clear to zero on reset
// - dac high holds code bits eleven to four, fully read-write
`timescale 1ns/10ps
`default_nettype none
`include "afe_ctrl_cfg.svh"
module afe_ctrl_regs
   import afe_ctrl_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic [1:0] ref_pair_sel,
   output logic conv_gain_sel,
   output logic amp_enable,
   output logic amp_bypass,
   output logic [7:0] amp_gain,
   output logic input_short,
   output logic [1:0] input_route_sel,
   output logic [8:0] neg_input_onehot,
   output logic [8:0] pos_input_onehot,
   output logic lownoise_amp_enable,
   output logic lownoise_pos_input_sel,
   output logic lownoise_switch_b,
   output logic lownoise_switch_a,
   output logic [11:0] dac_code
);
   // ======================================================
   // state
   typedef struct packed {
      logic [7:0] gain_ref;
      logic [7:0] conn;
      logic [7:0] chan;
      logic [7:0] lownoise;
      logic [7:0] dac_high;
      logic [7:0] dac_low;
      logic [7:0] dac_shadow;
      logic [31:0] rdata;
      logic ready;
      logic err;
      logic [1:0] ref_pair;
      logic conv_gain;
      logic amp_en;
      logic amp_byp;
      logic [7:0] amp_gain;
      logic in_short;
      logic [1:0] route;
      logic ln_en;
      logic ln_pos;
      logic ln_sw_b;
      logic ln_sw_a;
      logic [11:0] dac_code;
   } state_t;

   state_t state_reg;
   state_t state_next;

   function automatic logic addr_known(input logic [7:0] a);
      addr_known = (a == `OFF_AMP_GAIN_REF) || (a == `OFF_INPUT_CONN) ||
                   (a == `OFF_CHAN_SEL) || (a == `OFF_LOWNOISE) ||
                   (a == `OFF_DAC_HIGH) || (a == `OFF_DAC_LOW);
   endfunction

   // gain = 2 ** code, as a one-hot weight
   function automatic logic [7:0] pow2(input logic [2:0] c);
      pow2 = 8'h01 << c;
   endfunction

   logic setup;
   logic access;
   logic wr_en;
   logic lane0;
   logic [7:0] wbyte;
   logic [31:0] rd_mux;

   assign setup = psel && !penable;
   assign lane0 = pstrb[0];
   assign wbyte = pwdata[7:0];
   // a write lands only at the edge where the master sees pready high,
   // so an unfinished transfer can never change a register
   assign access = psel && penable && state_reg.ready;
   assign wr_en = access && pwrite && addr_known(paddr) && lane0;

   always_comb begin
      rd_mux = 32'h0000_0000;
      case (paddr)
         `OFF_AMP_GAIN_REF: rd_mux = {24'h00_0000, state_reg.gain_ref};
         `OFF_INPUT_CONN: rd_mux = {24'h00_0000, state_reg.conn};
         `OFF_CHAN_SEL: rd_mux = {24'h00_0000, state_reg.chan};
         `OFF_LOWNOISE: rd_mux = {24'h00_0000, state_reg.lownoise};
         `OFF_DAC_HIGH: rd_mux = {24'h00_0000, state_reg.dac_high};
         `OFF_DAC_LOW: rd_mux = {24'h00_0000, state_reg.dac_low};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // ======================================================
   // next state
   always_comb begin
      state_next = state_reg;
      state_next.ready = setup;
      state_next.err = setup && !addr_known(paddr);
      if (setup && !pwrite) begin
         state_next.rdata = rd_mux;
      end else if (setup) begin
         state_next.rdata = 32'h0000_0000;
      end
      if (wr_en) begin
         case (paddr)
            `OFF_AMP_GAIN_REF: state_next.gain_ref = wbyte;
            `OFF_INPUT_CONN:
               state_next.conn = wbyte & `MASK_INPUT_CONN;
            `OFF_CHAN_SEL: state_next.chan = wbyte;
            `OFF_LOWNOISE:
               state_next.lownoise = wbyte & `MASK_LOWNOISE;
            `OFF_DAC_HIGH: begin
               state_next.dac_high = wbyte;
               state_next.dac_low = state_reg.dac_shadow;
            end
            `OFF_DAC_LOW:
               state_next.dac_shadow = wbyte & `MASK_DAC_LOW;
            default: state_next.chan = state_reg.chan;
         endcase
      end
      // analog control decode, all from stored fields
      state_next.ref_pair = state_reg.gain_ref[`POS_REF_PAIR +: 2];
      state_next.conv_gain = state_reg.gain_ref[`POS_CONV_GAIN];
      state_next.amp_en = state_reg.gain_ref[`POS_AMP_EN];
      // disabled amplifier presents no bypass, unity gain, no routing
      state_next.amp_byp = state_next.amp_en &&
                           state_reg.gain_ref[`POS_AMP_BYP];
      state_next.amp_gain = state_next.amp_en ?
                            pow2(state_reg.gain_ref[2:0]) : 8'h01;
      state_next.in_short = state_next.amp_en &&
                            state_reg.conn[`POS_SHORT];
      state_next.route = state_next.amp_en ?
                         state_reg.conn[`POS_ROUTE +: 2] : 2'h0;
      state_next.ln_en = state_reg.lownoise[`POS_LN_EN];
      state_next.ln_pos = state_reg.lownoise[`POS_LN_POS];
      state_next.ln_sw_b = state_reg.lownoise[1];
      state_next.ln_sw_a = state_reg.lownoise[0];
      state_next.dac_code = {state_reg.dac_high,
                             state_reg.dac_low[3:0]};
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg <= '0;
         // gain is a weight, never zero, even while held in reset
         state_reg.amp_gain <= 8'h01;
      end else begin
         state_reg <= state_next;
      end
   end

   // ======================================================
   // multiplexer decode
   mux_decode u_neg (
      .clk(clk),
      .rst(rst),
      .code(state_reg.chan[`POS_NEG_SEL +: 4]),
      .onehot(neg_input_onehot)
   );
   mux_decode u_pos (
      .clk(clk),
      .rst(rst),
      .code(state_reg.chan[3:0]),
      .onehot(pos_input_onehot)
   );

   assign prdata = state_reg.rdata;
   assign pready = state_reg.ready;
   assign pslverr = state_reg.err;
   assign ref_pair_sel = state_reg.ref_pair;
   assign conv_gain_sel = state_reg.conv_gain;
   assign amp_enable = state_reg.amp_en;
   assign amp_bypass = state_reg.amp_byp;
   assign amp_gain = state_reg.amp_gain;
   assign input_short = state_reg.in_short;
   assign input_route_sel = state_reg.route;
   assign lownoise_amp_enable = state_reg.ln_en;
   assign lownoise_pos_input_sel = state_reg.ln_pos;
   assign lownoise_switch_b = state_reg.ln_sw_b;
   assign lownoise_switch_a = state_reg.ln_sw_a;
   assign dac_code = state_reg.dac_code;

   // ======================================================
   // checks
   sequence s_low_write;
      access && pwrite && lane0 && paddr == `OFF_DAC_LOW;
   endsequence
   sequence s_high_write;
      access && pwrite && lane0 && paddr == `OFF_DAC_HIGH;
   endsequence

   // analog levels trail the stored fields by one edge
   AST_REF_PAIR: assert property (@(posedge clk) disable iff (rst)
      ##1 ref_pair_sel == $past(state_reg.gain_ref[7:6]))
      else $error("reference pair output wrong");

   AST_CONV_GAIN: assert property (@(posedge clk) disable iff (rst)
      ##1 conv_gain_sel == $past(state_reg.gain_ref[5]))
      else $error("converter gain output wrong");

   AST_AMP_EN: assert property (@(posedge clk) disable iff (rst)
      ##1 amp_enable == $past(state_reg.gain_ref[4]))
      else $error("amplifier enable output wrong");

   AST_AMP_GATE: assert property (@(posedge clk) disable iff (rst)
      !amp_enable |-> !amp_bypass && !input_short &&
                      input_route_sel == 2'h0 && amp_gain == 8'h01)
      else $error("amplifier function active while disabled");

   AST_BYPASS: assert property (@(posedge clk) disable iff (rst)
      ##1 amp_bypass == ($past(state_reg.gain_ref[4]) &&
                         $past(state_reg.gain_ref[3])))
      else $error("bypass output wrong");

   AST_GAIN: assert property (@(posedge clk) disable iff (rst)
      amp_enable && state_reg.gain_ref[4] && $stable(state_reg.gain_ref)
      |-> ##1 amp_gain == (8'h01 << $past(state_reg.gain_ref[2:0])))
      else $error("amplifier gain wrong");

   AST_SHORT: assert property (@(posedge clk) disable iff (rst)
      ##1 input_short == ($past(state_reg.gain_ref[4]) &&
                          $past(state_reg.conn[7])))
      else $error("input short output wrong");

   AST_ROUTE: assert property (@(posedge clk) disable iff (rst)
      ##1 input_route_sel == ($past(state_reg.gain_ref[4]) ?
                              $past(state_reg.conn[6:5]) : 2'h0))
      else $error("input route output wrong");

   // one-hot selects trail the stored code by one edge
   AST_NEG_VCM: assert property (@(posedge clk) disable iff (rst)
      state_reg.chan[7:4] == 4'h8 |-> ##1 neg_input_onehot == 9'h010)
      else $error("negative mux decode wrong");

   AST_NEG_RESV: assert property (@(posedge clk) disable iff (rst)
      state_reg.chan[7:4] == 4'h5 |-> ##1 neg_input_onehot == 9'h000)
      else $error("reserved negative code selected an input");

   AST_POS_TEMP: assert property (@(posedge clk) disable iff (rst)
      state_reg.chan[3:0] == 4'ha |-> ##1 pos_input_onehot == 9'h040)
      else $error("positive mux decode wrong");

   AST_POS_GND: assert property (@(posedge clk) disable iff (rst)
      state_reg.chan[3:0] == 4'hf |-> ##1 pos_input_onehot == 9'h100)
      else $error("positive ground code not decoded");

   // low-noise amplifier controls
   AST_LN_EN: assert property (@(posedge clk) disable iff (rst)
      ##1 lownoise_amp_enable == $past(state_reg.lownoise[7]))
      else $error("low-noise enable output wrong");

   AST_LN_POS: assert property (@(posedge clk) disable iff (rst)
      ##1 lownoise_pos_input_sel == $past(state_reg.lownoise[2]))
      else $error("low-noise input select output wrong");

   AST_LN_SW: assert property (@(posedge clk) disable iff (rst)
      ##1 {lownoise_switch_b, lownoise_switch_a} ==
          $past(state_reg.lownoise[1:0]))
      else $error("low-noise switch outputs wrong");

   AST_LN_MASK: assert property (@(posedge clk) disable iff (rst)
      (state_reg.lownoise & 8'h78) == 8'h00 &&
      (state_reg.conn & 8'h1f) == 8'h00 &&
      (state_reg.dac_low & 8'hf0) == 8'h00)
      else $error("unimplemented bit stored");

   // storage: reset, refused writes, shadow and copy
   AST_RESET: assert property (@(posedge clk)
      rst |=> state_reg.gain_ref == 8'h00 && state_reg.conn == 8'h00 &&
              state_reg.chan == 8'h00 && state_reg.lownoise == 8'h00 &&
              state_reg.dac_low == 8'h00 && state_reg.dac_high == 8'h00)
      else $error("register not cleared by reset");

   AST_NO_LANE: assert property (@(posedge clk) disable iff (rst)
      access && pwrite && !lane0 |=> $stable(state_reg.chan) &&
                                     $stable(state_reg.gain_ref))
      else $error("write without byte lane changed a register");

   AST_SHADOW: assert property (@(posedge clk) disable iff (rst)
      s_low_write |=> $stable(state_reg.dac_low))
      else $error("dac low changed before high write");

   AST_COPY: assert property (@(posedge clk) disable iff (rst)
      s_high_write |=> state_reg.dac_low == $past(state_reg.dac_shadow) &&
                       state_reg.dac_high == $past(pwdata[7:0]))
      else $error("dac high write did not copy shadow");

   AST_DAC_CODE: assert property (@(posedge clk) disable iff (rst)
      ##1 dac_code == {$past(state_reg.dac_high),
                       $past(state_reg.dac_low[3:0])})
      else $error("dac code output wrong");

   // bus answer
   AST_READY: assert property (@(posedge clk) disable iff (rst)
      setup |=> pready)
      else $error("no answer one cycle after setup");

   AST_READY_ONCE: assert property (@(posedge clk) disable iff (rst)
      !setup |=> !pready)
      else $error("answer without a setup cycle");

   AST_ERR: assert property (@(posedge clk) disable iff (rst)
      setup && !addr_known(paddr) |=> pslverr && pready)
      else $error("unmapped address not refused");

   AST_ERR_QUIET: assert property (@(posedge clk) disable iff (rst)
      !setup |=> !pslverr)
      else $error("error flag raised without a setup cycle");

   AST_READ_DATA: assert property (@(posedge clk) disable iff (rst)
      setup && !pwrite && paddr == `OFF_CHAN_SEL |=>
         prdata == {24'h00_0000, $past(state_reg.chan)})
      else $error("read data not the stored channel code");
endmodule // afe_ctrl_regs
`default_nettype wire

// [bench/tb_top.sv]
// Purpose: self-checking bench for the front-end control register bank
// Assumes: APB slave answers at the first edge after penable rises; outputs settle after commit
// Notes: every scenario is its own task and judges its own results
`timescale 1ns/10ps
`default_nettype none
`include "afe_ctrl_cfg.svh"
module tb_top
   import afe_ctrl_pkg::*;
;
   logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic [3:0] pstrb = 4'hf;
   logic pready, pslverr, conv_gain_sel, amp_enable, amp_bypass, input_short;
   logic [1:0] ref_pair_sel, input_route_sel;
   logic [7:0] amp_gain, rd;
   logic [8:0] neg_input_onehot, pos_input_onehot;
   logic lownoise_amp_enable, lownoise_pos_input_sel;
   logic lownoise_switch_b, lownoise_switch_a, err;
   logic [11:0] dac_code;
   int fail_count = 0, check_count = 0;
   afe_ctrl_regs u_dut (.clk(clk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ref_pair_sel(ref_pair_sel), .conv_gain_sel(conv_gain_sel),
      .amp_enable(amp_enable), .amp_bypass(amp_bypass),
      .amp_gain(amp_gain), .input_short(input_short),
      .input_route_sel(input_route_sel),
      .neg_input_onehot(neg_input_onehot),
      .pos_input_onehot(pos_input_onehot),
      .lownoise_amp_enable(lownoise_amp_enable),
      .lownoise_pos_input_sel(lownoise_pos_input_sel),
      .lownoise_switch_b(lownoise_switch_b),
      .lownoise_switch_a(lownoise_switch_a), .dac_code(dac_code));
   // ======================================================
   // helpers
   initial begin
      forever #2 clk = ~clk;
   end
   task automatic tally_and_finish();
      if (fail_count == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, g);
      check_count++;
      if (g !== e) begin
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
         fail_count++;
      end
   endtask
   // one APB transfer; an edge passes first, so two calls in a row never
   // assign the same strobe twice in one time step; only the watchdog
   // ends a wait for the answer
   task automatic apb(input logic w, input logic [7:0] a, d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h00_0000, d};
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1);
      chk("answer cycles", 1, n);
      rd = prdata[7:0];
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdc(input logic [7:0] a, e);
      apb(0, a, 8'h00);
      chk("read data", e, rd);
      chk("read err", 0, err);
   endtask
   // outputs follow one edge after the commit edge; look once they stand
   task automatic settle();
      repeat (2) @(posedge clk);
      #1;
   endtask
   function automatic logic [8:0] hot(input logic [3:0] c);
      case (c)
         4'h0, 4'h1, 4'h2, 4'h3: hot = 9'h001 << c;
         4'h8: hot = 9'h010;
         4'h9: hot = 9'h020;
         4'ha: hot = 9'h040;
         4'hb: hot = 9'h080;
         4'hf: hot = 9'h100;
         default: hot = 9'h000;
      endcase
   endfunction
   // ======================================================
   // scenarios
   task automatic t_reset();
      #1;
      chk("gain", 8'h01, amp_gain);
      chk("dac", 12'h000, dac_code);
      chk("neg hot", 9'h001, neg_input_onehot);
      chk("amp en", 0, amp_enable);
      chk("ln en", 0, lownoise_amp_enable);
      chk("ln pos", 0, lownoise_pos_input_sel);
      chk("ln sw", 2'h0, {lownoise_switch_b, lownoise_switch_a});
      @(posedge clk);
      rdc(`OFF_AMP_GAIN_REF, 8'h00);
      rdc(`OFF_INPUT_CONN, 8'h00);
      rdc(`OFF_CHAN_SEL, 8'h00);
      rdc(`OFF_LOWNOISE, 8'h00);
      rdc(`OFF_DAC_HIGH, 8'h00);
      rdc(`OFF_DAC_LOW, 8'h00);
   endtask
   task automatic t_gain();
      logic [7:0] d;
      for (int i = 0; i < 8; i++) begin
         d = {i[1:0], i[0], 1'b1, 1'b0, i[2:0]};
         apb(1, `OFF_AMP_GAIN_REF, d);
         settle();
         chk("amp gain", 8'h01 << i, amp_gain);
         chk("ref pair", i[1:0], ref_pair_sel);
         chk("conv gain", i[0], conv_gain_sel);
         chk("bypass", 0, amp_bypass);
         chk("amp en", 1, amp_enable);
         rdc(`OFF_AMP_GAIN_REF, d);
      end
      apb(1, `OFF_AMP_GAIN_REF, 8'h1d);
      apb(1, `OFF_INPUT_CONN, 8'hff);
      settle();
      chk("bypass", 1, amp_bypass);
      chk("short", 1, input_short);
      chk("route", 2'h3, input_route_sel);
      rdc(`OFF_INPUT_CONN, 8'he0);
      apb(1, `OFF_AMP_GAIN_REF, 8'h0d);
      settle();
      chk("off gain", 8'h01, amp_gain);
      chk("off bypass", 0, amp_bypass);
      chk("off short", 0, input_short);
      chk("off route", 2'h0, input_route_sel);
      chk("off en", 0, amp_enable);
   endtask
   task automatic t_mux();
      logic [3:0] c;
      apb(1, `OFF_CHAN_SEL, 8'h80);
      settle();
      chk("single neg", 9'h010, neg_input_onehot);
      chk("single pos", 9'h001, pos_input_onehot);
      apb(1, `OFF_CHAN_SEL, 8'haa);
      settle();
      chk("temp neg", 9'h040, neg_input_onehot);
      chk("temp pos", 9'h040, pos_input_onehot);
      for (int i = 0; i < 16; i++) begin
         c = i[3:0];
         apb(1, `OFF_CHAN_SEL, {c, ~c});
         settle();
         chk("neg hot", hot(c), neg_input_onehot);
         chk("pos hot", hot(~c), pos_input_onehot);
         rdc(`OFF_CHAN_SEL, {c, ~c});
      end
   endtask
   task automatic t_lownoise();
      apb(1, `OFF_LOWNOISE, 8'hff);
      settle();
      rdc(`OFF_LOWNOISE, 8'h87);
      chk("ln en", 1, lownoise_amp_enable);
      chk("ln pos", 1, lownoise_pos_input_sel);
      chk("ln sw", 2'h3, {lownoise_switch_b, lownoise_switch_a});
      apb(1, `OFF_LOWNOISE, 8'h05);
      settle();
      chk("ln en", 0, lownoise_amp_enable);
      chk("ln sw", 2'h1, {lownoise_switch_b, lownoise_switch_a});
      chk("ln pos", 1, lownoise_pos_input_sel);
      apb(1, `OFF_LOWNOISE, 8'h80);
      settle();
      chk("ln en", 1, lownoise_amp_enable);
      chk("ln pos", 0, lownoise_pos_input_sel);
      chk("ln sw", 2'h0, {lownoise_switch_b, lownoise_switch_a});
   endtask
   task automatic t_dac();
      apb(1, `OFF_DAC_LOW, 8'hfa);
      settle();
      rdc(`OFF_DAC_LOW, 8'h00);
      chk("dac early", 12'h000, dac_code);
      apb(1, `OFF_DAC_HIGH, 8'ha5);
      settle();
      chk("dac", 12'ha5a, dac_code);
      rdc(`OFF_DAC_HIGH, 8'ha5);
      rdc(`OFF_DAC_LOW, 8'h0a);
      apb(1, `OFF_DAC_LOW, 8'h03);
      settle();
      chk("dac held", 12'ha5a, dac_code);
   endtask
   task automatic t_refuse();
      apb(0, 8'h18, 8'h00);
      chk("unmapped err", 1, err);
      chk("unmapped rd", 8'h00, rd);
      apb(1, 8'h18, 8'hff);
      chk("unmapped err", 1, err);
      pstrb <= 4'h0;
      apb(1, `OFF_CHAN_SEL, 8'h12);
      chk("no lane err", 0, err);
      pstrb <= 4'hf;
      rdc(`OFF_CHAN_SEL, 8'hf0);
   endtask
   // ======================================================
   // main sequence and watchdog
   initial begin
      repeat (12) @(posedge clk);
      rst <= 0;
      @(posedge clk);
      t_reset();
      t_gain();
      t_mux();
      t_lownoise();
      t_dac();
      @(posedge clk);
      t_refuse();
      tally_and_finish();
   end
   initial begin
      #40000;
      fail_count++;
      tally_and_finish();
   end
endmodule // tb_top
`default_nettype wire
